//--- rtl/vmsc_pkg.sv
package vmsc_pkg;
   // register offsets on the serial slave port
   localparam logic [7:0] A_CFG_REF = 8'h11;
   localparam logic [7:0] A_SUMMARY = 8'h12;
   localparam logic [7:0] A_CFG_CHAN = 8'h13;
   localparam logic [7:0] A_EXT_A = 8'h1F;
   localparam logic [7:0] A_AVG = 8'h40;
   localparam logic [7:0] A_CFG_ADC = 8'h73;
   localparam logic [7:0] A_EXT_B = 8'h76;
   localparam logic [7:0] A_EXT_C = 8'h77;
   localparam logic [7:0] A_CFG_BYP = 8'h7D;
   // channel order: reference rail, 2.5 V, core, supply, 5 V, 12 V
   localparam int NCH = 6;
   localparam logic [2:0] CH_REF = 3'h0;
   localparam logic [2:0] CH_SUP = 3'h3;
   localparam logic [2:0] CH_12V = 3'h5;
   localparam logic [7:0] RD_ADDR [NCH] = '{8'h1E, 8'h20, 8'h21, 8'h22,
                                            8'h23, 8'h24};
   localparam logic [7:0] LO_ADDR [NCH] = '{8'h84, 8'h44, 8'h46, 8'h48,
                                            8'h4A, 8'h4C};
   localparam logic [7:0] HI_ADDR [NCH] = '{8'h86, 8'h45, 8'h47, 8'h49,
                                            8'h4B, 8'h4D};
   // status / mask pairs: 0x41,0x42,0x43,0x81,0x7E,0xB6..0xBA
   localparam int NST = 10;
   localparam logic [7:0] ST_ADDR [NST] = '{8'h41, 8'h42, 8'h43, 8'h81,
      8'h7E, 8'hB6, 8'hB7, 8'hB8, 8'hB9, 8'hBA};
   localparam logic [7:0] MK_ADDR [NST] = '{8'h74, 8'h75, 8'h82, 8'h83,
      8'h7F, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC0};
   // field positions
   localparam int REF_SEL_BIT = 2;
   localparam int AVG_MSB = 7;
   localparam int AVG_LSB = 6;
   localparam int AVG_OFF_BIT = 3;
   localparam int SUM_BIT = 7;
   localparam int OVERTEMP_SIGNAL_SUM_BIT = 7;
   // converter
   localparam int ADC_BITS = 10;
   localparam int REF_MV = 2000;
   localparam int LSB_NV = REF_MV * 1000000 / (1 << ADC_BITS);
   localparam logic [9:0] NOMINAL_CODE = 10'h300;
   localparam logic [2:0] AVG_BASE_SHIFT = 3'h2;
   // values after reset
   localparam logic [7:0] RST_CFG_REF = 8'h04;
   localparam logic [7:0] RST_CFG_CHAN = 8'hF8;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_LIM_HI = 8'hFF;
   // monitoring loop states
   typedef enum logic [3:0] {
      ST_PICK = 4'h1,
      ST_START = 4'h2,
      ST_WAIT = 4'h4,
      ST_STORE = 4'h8
   } vmsc_state_type;
endpackage

//--- rtl/vmsc_top.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// (R1) summary flag bits never drive the alert
// (R2) summary register 0x12 has no mask
// (R3) each monitoring status register has its mask
// (R4) master error statuses masked by 0xBC..0xC0
// (R5) status registers chain through summary flag bits
// (R6) one shared converter, 10-bit results
// (R7) nominal attenuated input gives code 768
// (R8) six read-only results, zero after reset
// (R9) extended read freezes results until read
// (R10) host reads extended first, then result
// (R11) 0x11 bit 2 adds reference rail channel
// (R12) 0x13 bits 7:3 select other channels
// (R13) bypassed step is 2 V over 10 bits
// (R14) compare results to high and low limits
// (R15) limit pairs at their fixed offsets
// (R16) averaging length 4/8/16/32 from 0x40
// (R17) 0x73 bit 3 turns voltage averaging off
// (R18) 0x7D bits 7:3 bypass attenuators
// (R19) supply channel has no bypass
// (R20) status bits stick until register read
// (R21) unmasked status bit asserts alert pin
// (R22) mask stops alert, not the status bit
// (R23) round-robin, store and compare in the same cycle after averaging
module vmsc_top
   import vmsc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic conv_start_o,
   output logic [2:0] conv_chan_o,
   output logic conv_bypass_o,
   input wire logic conv_done_i,
   input wire logic [9:0] conv_data_i,
   input wire logic [1:0] temp_evt_i,
   input wire logic [6:0] vfan_evt_i,
   input wire logic [6:0] linka_evt_i,
   input wire logic [6:0] linkb_evt_i,
   input wire logic [7:0] push_evt_i,
   input wire logic [7:0] mst_nack_evt_i,
   input wire logic [7:0] mst_pec_evt_i,
   input wire logic [7:0] mst_tout_evt_i,
   input wire logic [7:0] mst_lim_evt_i,
   input wire logic [7:0] mst_inv_evt_i,
   input wire logic overtemp_signal_pending_i,
   input wire logic alert_pin_en_i,
   output logic alert_o
);

   // next enabled channel after cur, in fixed round-robin order
   function automatic logic [2:0] next_chan(input logic [2:0] cur,
                                            input logic [5:0] en);
      logic [2:0] pick;
      int idx;
      pick = cur;
      for (int i = NCH; i >= 1; i--) begin
         idx = (int'(cur) + i) % NCH;
         if (en[idx]) begin
            pick = 3'(idx);
         end
      end
      return pick;
   endfunction

   // configuration registers
   logic [7:0] cfg_ref_q; // reference rail select
   logic [7:0] cfg_chan_q; // channel select
   logic [7:0] cfg_avg_q; // averager length
   logic [7:0] cfg_adc_q; // converter functions
   logic [7:0] cfg_byp_q; // attenuator bypass
   logic [7:0] lim_lo_q [NCH]; // low limits
   logic [7:0] lim_hi_q [NCH]; // high limits
   // results and freeze
   logic [9:0] res_q [NCH]; // 10-bit averaged results
   logic [5:0] lock_q; // frozen result channels
   // status and masks
   logic [7:0] st_q [NST]; // sticky status bits
   logic [7:0] mk_q [NST]; // alert masks
   logic [7:0] rv [NST]; // status as read, summaries included
   logic [7:0] evt [NST]; // set requests this cycle
   logic [7:0] summary; // top-level summary value
   // loop
   vmsc_state_type state_q;
   logic [2:0] ch_q; // channel being converted
   logic [14:0] acc_q; // sample sum
   logic [5:0] cnt_q; // samples taken
   logic [5:0] en; // channels in the loop
   logic [5:0] byp; // bypass per channel
   logic [5:0] n_samples; // samples per result
   logic [2:0] shift; // divide by n_samples
   logic [9:0] avg; // averaged value
   logic hit; // current result outside limits
   logic [5:0] oor; // out-of-range pulse per channel
   logic conv_start_q;
   logic conv_bypass_q;
   logic alert_q;
   logic [7:0] rdata_q;
   logic [7:0] rd_d;
   logic any_unmasked;

   // channel enables and bypass bits
   always_comb begin
      en[0] = cfg_ref_q[REF_SEL_BIT]; // see (R11)
      en[1] = cfg_chan_q[6]; // see (R12)
      en[2] = cfg_chan_q[5];
      en[3] = cfg_chan_q[7];
      en[4] = cfg_chan_q[4];
      en[5] = cfg_chan_q[3];
      byp[0] = cfg_byp_q[3]; // see (R18)
      byp[1] = cfg_byp_q[4];
      byp[2] = cfg_byp_q[5];
      byp[3] = 1'b0; // supply attenuator always in, see (R19)
      byp[4] = cfg_byp_q[6];
      byp[5] = cfg_byp_q[7];
   end

   // averaging length, or one sample when averaging is off
   always_comb begin
      if (cfg_adc_q[AVG_OFF_BIT]) begin // see (R17)
         shift = 3'h0;
      end else begin // see (R16)
         shift = AVG_BASE_SHIFT + {1'b0, cfg_avg_q[AVG_MSB:AVG_LSB]};
      end
      n_samples = 6'(1 << shift);
      avg = 10'(acc_q >> shift);
   end

   // limit check of the averaged value, top eight bits
   always_comb begin
      hit = (avg[9:2] > lim_hi_q[ch_q]) ||
            (avg[9:2] < lim_lo_q[ch_q]); // see (R14)
      oor = '0;
      if (state_q == ST_STORE) begin // see (R23)
         oor[ch_q] = hit;
      end
   end

   // monitoring loop over the one shared converter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_PICK;
         ch_q <= CH_12V;
         acc_q <= '0;
         cnt_q <= '0;
      end else begin
         case (state_q)
            ST_PICK: begin
               // idle while no channel is selected
               if (|en) begin
                  ch_q <= next_chan(ch_q, en); // see (R23) (R6)
                  acc_q <= '0;
                  cnt_q <= '0;
                  state_q <= ST_START;
               end
            end
            ST_START: begin
               state_q <= ST_WAIT;
            end
            ST_WAIT: begin
               // accumulate one sample per finished conversion
               if (conv_done_i) begin
                  acc_q <= acc_q + {5'h00, conv_data_i}; // see (R6)
                  cnt_q <= cnt_q + 6'h01;
                  if (cnt_q + 6'h01 == n_samples) begin
                     state_q <= ST_STORE;
                  end else begin
                     state_q <= ST_START;
                  end
               end
            end
            ST_STORE: begin
               state_q <= ST_PICK;
            end
            default: begin
               state_q <= ST_PICK;
            end
         endcase
      end
   end

   // converter request, channel and bypass select
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_start_q <= 1'b0;
         conv_bypass_q <= 1'b0;
      end else begin
         conv_start_q <= (state_q == ST_START);
         conv_bypass_q <= byp[ch_q]; // see (R13) (R18)
      end
   end

   // result registers, held while frozen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NCH; i++) begin
            res_q[i] <= '0; // see (R8)
         end
      end else if (state_q == ST_STORE && !lock_q[ch_q]) begin
         res_q[ch_q] <= avg; // see (R23) (R9)
      end
   end

   // freeze set by extended read, released by result read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_q <= '0;
      end else if (reg_rd_i) begin
         // see (R9)
         if (reg_addr_i == A_EXT_A) begin
            lock_q[0] <= 1'b1;
         end else if (reg_addr_i == A_EXT_B) begin
            lock_q[4:1] <= 4'hF;
         end else if (reg_addr_i == A_EXT_C) begin
            lock_q[5] <= 1'b1;
         end
         for (int i = 0; i < NCH; i++) begin
            if (reg_addr_i == RD_ADDR[i]) begin
               lock_q[i] <= 1'b0;
            end
         end
      end
   end

   // configuration and limit registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_ref_q <= RST_CFG_REF;
         cfg_chan_q <= RST_CFG_CHAN;
         cfg_avg_q <= RST_ZERO;
         cfg_adc_q <= RST_ZERO;
         cfg_byp_q <= RST_ZERO;
         for (int i = 0; i < NCH; i++) begin
            lim_lo_q[i] <= RST_ZERO;
            lim_hi_q[i] <= RST_LIM_HI;
         end
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            A_CFG_REF: cfg_ref_q <= reg_wdata_i;
            A_CFG_CHAN: cfg_chan_q <= reg_wdata_i;
            A_AVG: cfg_avg_q <= reg_wdata_i;
            A_CFG_ADC: cfg_adc_q <= reg_wdata_i;
            A_CFG_BYP: cfg_byp_q <= reg_wdata_i;
            default: begin
            end
         endcase
         for (int i = 0; i < NCH; i++) begin
            if (reg_addr_i == LO_ADDR[i]) begin
               lim_lo_q[i] <= reg_wdata_i; // see (R15)
            end
            if (reg_addr_i == HI_ADDR[i]) begin
               lim_hi_q[i] <= reg_wdata_i; // see (R15)
            end
         end
      end
   end

   // mask registers, one per status register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NST; i++) begin
            mk_q[i] <= RST_ZERO;
         end
      end else if (reg_wr_i) begin
         for (int i = 0; i < NST; i++) begin
            if (reg_addr_i == MK_ADDR[i]) begin
               mk_q[i] <= reg_wdata_i; // see (R3) (R4)
            end
         end
      end
   end

   // events feeding each status register; bit 7 of the first
   // three is the live summary flag bit and is never stored
   always_comb begin
      evt[0] = {1'b0, temp_evt_i, oor[5:1]};
      evt[1] = {1'b0, vfan_evt_i};
      evt[2] = {1'b0, linka_evt_i};
      evt[3] = {linkb_evt_i, oor[0]};
      evt[4] = push_evt_i;
      evt[5] = mst_nack_evt_i;
      evt[6] = mst_pec_evt_i;
      evt[7] = mst_tout_evt_i;
      evt[8] = mst_lim_evt_i;
      evt[9] = mst_inv_evt_i;
   end

   // sticky status, cleared by read; a same-cycle set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NST; i++) begin
            st_q[i] <= RST_ZERO;
         end
      end else begin
         for (int i = 0; i < NST; i++) begin
            if (reg_rd_i && reg_addr_i == ST_ADDR[i]) begin
               st_q[i] <= evt[i]; // see (R20)
            end else begin
               st_q[i] <= st_q[i] | evt[i]; // see (R22) (R20)
            end
         end
      end
   end

   // read view with chained summary flag bits
   always_comb begin
      for (int i = 3; i < NST; i++) begin
         rv[i] = st_q[i];
      end
      rv[2] = {|rv[3], st_q[2][6:0]}; // see (R5)
      rv[1] = {|rv[2], st_q[1][6:0]};
      rv[0] = {|rv[1], st_q[0][6:0]};
      summary = {overtemp_signal_pending_i, |rv[9], |rv[8], |rv[7], |rv[6],
                 |rv[5], |rv[4], |rv[0]}; // see (R2)
   end

   // alert: stored bits not masked; summaries take no part
   always_comb begin
      any_unmasked = 1'b0;
      for (int i = 0; i < NST; i++) begin
         any_unmasked = any_unmasked | (|(st_q[i] & ~mk_q[i])); // see (R22)
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alert_q <= 1'b0;
      end else begin
         alert_q <= alert_pin_en_i && any_unmasked; // see (R21) (R1)
      end
   end

   // read data multiplexer
   always_comb begin
      rd_d = 8'h00;
      case (reg_addr_i)
         A_CFG_REF: rd_d = cfg_ref_q;
         A_SUMMARY: rd_d = summary;
         A_CFG_CHAN: rd_d = cfg_chan_q;
         A_EXT_A: rd_d = {6'h00, res_q[0][1:0]};
         A_EXT_B: rd_d = {res_q[4][1:0], res_q[3][1:0], res_q[2][1:0],
                          res_q[1][1:0]};
         A_EXT_C: rd_d = {6'h00, res_q[5][1:0]};
         A_AVG: rd_d = cfg_avg_q;
         A_CFG_ADC: rd_d = cfg_adc_q;
         A_CFG_BYP: rd_d = cfg_byp_q;
         default: begin
         end
      endcase
      for (int i = 0; i < NCH; i++) begin
         if (reg_addr_i == RD_ADDR[i]) begin
            rd_d = res_q[i][9:2];
         end
         if (reg_addr_i == LO_ADDR[i]) begin
            rd_d = lim_lo_q[i];
         end
         if (reg_addr_i == HI_ADDR[i]) begin
            rd_d = lim_hi_q[i];
         end
      end
      for (int i = 0; i < NST; i++) begin
         if (reg_addr_i == ST_ADDR[i]) begin
            rd_d = rv[i];
         end
         if (reg_addr_i == MK_ADDR[i]) begin
            rd_d = mk_q[i];
         end
      end
   end

   // read data register, loaded on each read strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_i) begin
         rdata_q <= rd_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign conv_start_o = conv_start_q;
   assign conv_chan_o = ch_q;
   assign conv_bypass_o = conv_bypass_q;
   assign alert_o = alert_q;

   // checks
   a_alert_raise: assert property (@(posedge clk_i) disable iff (rst_i) // see (R21)
      alert_pin_en_i && any_unmasked |=> alert_o)
      else $error("alert not raised for unmasked status");
   a_alert_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // see (R22)
      !any_unmasked |=> !alert_o)
      else $error("alert raised with all status masked");
   a_summary_no_alert: assert property (@(posedge clk_i) // see (R1)
      disable iff (rst_i)
      (st_q[0][SUM_BIT] | st_q[1][SUM_BIT] | st_q[2][SUM_BIT]) == 1'b0)
      else $error("summary flag bit stored as status");
   a_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // see (R20)
      st_q[0][0] && !(reg_rd_i && reg_addr_i == ST_ADDR[0]) |=> st_q[0][0])
      else $error("status bit lost without read");
   a_limit_flag: assert property (@(posedge clk_i) disable iff (rst_i) // see (R14)
      state_q == ST_STORE && hit && ch_q == CH_REF |=> st_q[3][0])
      else $error("limit violation not flagged");
   a_lock_hold: assert property (@(posedge clk_i) disable iff (rst_i) // see (R9)
      lock_q[1] && !(reg_rd_i && reg_addr_i == RD_ADDR[1])
      |=> $stable(res_q[1]) && lock_q[1])
      else $error("frozen result changed");
   a_sample_count: assert property (@(posedge clk_i) disable iff (rst_i) // see (R16)
      state_q == ST_STORE |-> cnt_q == n_samples
      && (!cfg_adc_q[AVG_OFF_BIT] || cnt_q == 6'h01))
      else $error("wrong number of samples averaged");
   a_chan_enabled: assert property (@(posedge clk_i) disable iff (rst_i) // see (R12)
      state_q == ST_PICK && |en |=> en[ch_q] ##1 conv_start_o)
      else $error("deselected channel converted");
   a_supply_no_bypass: assert property (@(posedge clk_i) // see (R19)
      disable iff (rst_i)
      conv_start_o && ch_q == CH_SUP |-> !conv_bypass_o)
      else $error("supply attenuator bypassed");
   c_store_nominal: cover property (@(posedge clk_i) disable iff (rst_i) // see (R7)
      state_q == ST_STORE && avg == NOMINAL_CODE);
   c_lock_read: cover property (@(posedge clk_i) disable iff (rst_i)
      lock_q[0] ##[1:20] (reg_rd_i && reg_addr_i == RD_ADDR[0]));
   c_alert: cover property (@(posedge clk_i) disable iff (rst_i)
      $rose(alert_o));

endmodule
`default_nettype wire

//--- bench/vmsc_conv_model.sv
`timescale 1ns/1ns
`default_nettype none
// converter model: one sample for every start, after a set delay
module vmsc_conv_model (
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic [2:0] chan_i,
   output logic done_o,
   output logic [9:0] data_o
);
   logic [9:0] val [6]; // sample value per channel, set by the bench
   int dly = 2; // cycles from start to the done pulse
   int cnt = 0; // countdown, 0 while idle
   logic [2:0] ch; // channel taken with the start
   initial begin
      done_o = 1'b0;
      data_o = 10'h155;
      foreach (val[i]) val[i] = 10'h000;
   end
   // data is only meaningful in the done cycle, so scramble it elsewhere
   always @(posedge clk_i) begin
      #1;
      done_o = 1'b0;
      data_o = ~data_o;
      if (cnt == 1) begin
         done_o = 1'b1;
         data_o = val[ch];
      end
      if (cnt > 0) cnt = cnt - 1;
      if (start_i) begin
         cnt = dly;
         ch = chan_i;
      end
   end
endmodule
`default_nettype wire

//--- bench/vmsc_top_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin failures++; \
   $display("mismatch %s exp %0h got %0h", n, e, a); end end
// self-checking bench for the monitor block
module vmsc_top_test
   import vmsc_pkg::*;
;
   logic clk, rst, wr, rd_s, st, byp, done, overtemp_signal, aen, alert;
   logic [7:0] addr, wdata, rdata;
   logic [2:0] ch;
   logic [9:0] data;
   logic [1:0] t_ev; // event pulses, one vector per status register
   logic [6:0] v_ev, a_ev, b_ev;
   logic [7:0] p_ev, n_ev, c_ev, o_ev, l_ev, i_ev;
   int failures = 0;
   int compares = 0;
   int nst = 0; // starts seen since last cleared
   int run = 0; // length of current run of starts on one channel
   int lrun = 0; // length of last finished run
   logic [2:0] lch = 3'h7;
   logic [5:0] seen = '0; // channels started since last cleared
   logic [7:0] bcfg = '0; // mirror of bypass config
   logic bchk = 1'b0; // bypass checks active
   vmsc_top dut (
      .clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
      .conv_start_o(st), .conv_chan_o(ch), .conv_bypass_o(byp),
      .conv_done_i(done), .conv_data_i(data), .temp_evt_i(t_ev),
      .vfan_evt_i(v_ev), .linka_evt_i(a_ev), .linkb_evt_i(b_ev),
      .push_evt_i(p_ev), .mst_nack_evt_i(n_ev), .mst_pec_evt_i(c_ev),
      .mst_tout_evt_i(o_ev), .mst_lim_evt_i(l_ev), .mst_inv_evt_i(i_ev),
      .overtemp_signal_pending_i(overtemp_signal), .alert_pin_en_i(aen), .alert_o(alert)
   );
   vmsc_conv_model m (
      .clk_i(clk), .start_i(st), .chan_i(ch), .done_o(done), .data_o(data)
   );
   // expected bypass level for a channel; supply has none
   function automatic logic byp_exp(input logic [2:0] c);
      return (c == CH_SUP) ? 1'b0 : bcfg[(c < CH_SUP) ? c + 3 : c + 2];
   endfunction
   // watch every start: bypass level, channel runs and coverage
   always @(posedge clk) begin
      if (!rst && st) begin
         if (bchk) `CHK("bypass", byp_exp(ch), byp)
         nst++;
         seen[ch] = 1'b1;
         if (ch == lch) begin
            run++;
         end else begin
            lrun = run;
            run = 1;
            lch = ch;
         end
      end
   end
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr_r(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      #1;
      addr = a;
      rd_s = 1'b1;
      cyc(1);
      rd_s = 1'b0;
      `CHK(n, e, rdata)
   endtask
   // wait for n converter starts, bounded
   task wst(input int n);
      int k;
      k = 0;
      nst = 0;
      while (nst < n && k < 5000) begin
         @(posedge clk);
         k++;
      end
      #1;
   endtask
   // one-cycle event pulse into status register i
   task fire(input int i);
      @(posedge clk);
      #1;
      case (i)
         0: t_ev = 2'h1;
         1: v_ev = 7'h01;
         2: a_ev = 7'h01;
         3: b_ev = 7'h01;
         4: p_ev = 8'h01;
         5: n_ev = 8'h01;
         6: c_ev = 8'h01;
         7: o_ev = 8'h01;
         8: l_ev = 8'h01;
         default: i_ev = 8'h01;
      endcase
      cyc(1);
      {t_ev, v_ev, a_ev, b_ev, p_ev, n_ev, c_ev, o_ev, l_ev, i_ev} = '0;
   endtask
   task t_reset;
      rd(A_CFG_REF, 8'h04, "cfg ref");
      rd(A_CFG_CHAN, 8'hF8, "cfg chan");
      wr_r(8'h20, 8'hFF);
      for (int i = 0; i < NCH; i++) begin
         rd(RD_ADDR[i], 8'h00, "result");
         rd(LO_ADDR[i], 8'h00, "low lim");
         rd(HI_ADDR[i], 8'hFF, "high lim");
      end
      rd(8'h01, 8'h00, "unmapped");
      $display("test reset done");
   endtask
   task t_avg;
      int n;
      wr_r(A_CFG_CHAN, 8'h08);
      for (int c = 0; c < 4; c++) begin
         wr_r(A_AVG, 8'(c << 6));
         n = 4 << c;
         wst(3 * n + 32);
         seen = '0;
         wst(2 * n);
         `CHK("run", n, lrun)
         `CHK("seen", 6'h21, seen)
      end
      wr_r(A_CFG_ADC, 8'h08);
      wr_r(A_CFG_BYP, 8'h50);
      bcfg = 8'h50;
      wr_r(A_CFG_REF, 8'h00);
      wr_r(A_CFG_CHAN, 8'hF8);
      wst(80);
      bchk = 1'b1;
      seen = '0;
      wst(12);
      bchk = 1'b0;
      `CHK("run", 1, lrun)
      `CHK("seen", 6'h3E, seen)
      $display("test averaging done");
   endtask
   task t_res;
      wr_r(A_CFG_CHAN, 8'h40);
      m.val[1] = 10'h300;
      wst(8);
      rd(8'h20, 8'hC0, "nominal");
      m.val[1] = 10'h2F3;
      wst(8);
      rd(A_EXT_B, 8'h03, "ext");
      m.val[1] = 10'h1FC;
      wst(8);
      rd(8'h20, 8'hBC, "frozen");
      wst(8);
      rd(8'h20, 8'h7F, "fresh");
      m.val[1] = 10'h2F3;
      $display("test result done");
   endtask
   task t_lim;
      rd(8'h41, 8'h00, "clean");
      wr_r(8'h45, 8'hB0);
      wst(8);
      `CHK("alert disabled", 1'b0, alert)
      aen = 1'b1;
      cyc(2);
      `CHK("alert", 1'b1, alert)
      rd(A_SUMMARY, 8'h01, "summary");
      wr_r(8'h45, 8'hFF);
      wst(8);
      rd(8'h41, 8'h01, "sticky");
      rd(8'h41, 8'h00, "cleared");
      wr_r(8'h74, 8'h01);
      wr_r(8'h44, 8'hC0);
      wst(8);
      `CHK("masked", 1'b0, alert)
      wr_r(8'h44, 8'h00);
      wst(8);
      rd(8'h41, 8'h01, "low");
      wr_r(8'h74, 8'h00);
      rd(8'h41, 8'h00, "low cleared");
      cyc(1);
      `CHK("alert off", 1'b0, alert)
      $display("test limit done");
   endtask
   task t_evt;
      logic [7:0] e;
      logic [7:0] s;
      for (int i = 0; i < NST; i++) begin
         e = (i == 0) ? 8'h20 : (i == 3) ? 8'h02 : 8'h01;
         s = (i == 0) ? 8'h01 : (i == 4) ? 8'h02 : 8'(1 << (i - 3));
         wr_r(MK_ADDR[i], 8'hFF);
         fire(i);
         cyc(2);
         `CHK("masked alert", 1'b0, alert)
         if (i >= 1 && i <= 3) begin
            rd(ST_ADDR[i - 1], 8'h80, "chain");
         end
         rd(ST_ADDR[i], e, "masked status");
         wr_r(MK_ADDR[i], 8'h00);
         fire(i);
         cyc(2);
         `CHK("alert", 1'b1, alert)
         if (i == 0 || i >= 4) begin
            rd(A_SUMMARY, s, "summary");
         end
         rd(ST_ADDR[i], e, "status");
         cyc(1);
         `CHK("alert off", 1'b0, alert)
      end
      overtemp_signal = 1'b1;
      cyc(1);
      rd(A_SUMMARY, 8'h80, "overtemp_signal");
      `CHK("overtemp_signal alert", 1'b0, alert)
      overtemp_signal = 1'b0;
      $display("test events done");
   endtask
   task end_of_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // free-running 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // hang guard, well above the expected run length
   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      end_of_test();
   end
   // main sequence
   initial begin
      {rst, wr, rd_s, overtemp_signal, aen} = 5'h10;
      {addr, wdata} = '0;
      {t_ev, v_ev, a_ev, b_ev, p_ev, n_ev, c_ev, o_ev, l_ev, i_ev} = '0;
      cyc(5);
      rst = 1'b0;
      t_reset();
      t_avg();
      t_res();
      t_lim();
      t_evt();
      end_of_test();
   end
endmodule
`default_nettype wire
